// File: logic/epi_pkg.sv
package epi_pkg;

  localparam int NUM_LINES = 3;
  localparam int LINE_A = 0;
  localparam int LINE_B = 1;
  localparam int LINE_C = 2;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ENABLE = 8'h04;
  localparam logic [7:0] OFF_FLAG = 8'h08;
  localparam logic [7:0] OFF_PIN = 8'h0C;
  localparam logic [7:0] OFF_SLEEP = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;

  // Field positions
  localparam int CTRL_A_SENSE_LSB = 0;
  localparam int CTRL_B_SENSE_LSB = 2;
  localparam int CTRL_C_SEL_BIT = 4;
  localparam int EN_GLOBAL_BIT = 7;
  localparam int PIN_DIR_LSB = 8;
  localparam int SLEEP_DEEP_BIT = 0;
  localparam int SLEEP_GO_BIT = 4;
  localparam int SLEEP_STATE_LSB = 8;
  localparam int STAT_REQ_LSB = 4;
  localparam int STAT_IORUN_BIT = 8;

  // Reset values
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam logic [2:0] ENABLE_RST = 3'h0;
  localparam logic [2:0] DRIVE_RST = 3'h0;
  localparam logic [2:0] DIR_RST = 3'h0;

  // Sense codes of the two-bit fields
  localparam logic [1:0] SENSE_LOW = 2'h0;
  localparam logic [1:0] SENSE_ANY = 2'h1;
  localparam logic [1:0] SENSE_FALL = 2'h2;
  localparam logic [1:0] SENSE_RISE = 2'h3;

  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int WDT_PERIOD_NS = 1000;
  localparam int WDT_TICK_CYCLES = WDT_PERIOD_NS / CLK_PERIOD_NS;
  localparam int WAKE_SAMPLES = 2;
  localparam int STARTUP0_US = 1;
  localparam int STARTUP1_US = 4;
  localparam int STARTUP2_US = 16;
  localparam int STARTUP3_US = 64;
  localparam int STARTUP0_CYC = (STARTUP0_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STARTUP1_CYC = (STARTUP1_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STARTUP2_CYC = (STARTUP2_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STARTUP3_CYC = (STARTUP3_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    ST_RUN = 4'b0001,
    ST_SLEEP = 4'b0010,
    ST_SAMPLE = 4'b0100,
    ST_STARTUP = 4'b1000
  } epi_state_t;

endpackage

// File: logic/epi_line_if.sv
`timescale 1ns/1ps
interface epi_line_if;
  logic [1:0] sense;
  logic sample_en;
  logic pin;
  logic edge_hit;
  modport det (input sense, input sample_en, input pin, output edge_hit);
  modport ctl (output sense, output sample_en, output pin, input edge_hit);
endinterface

// File: logic/epi_line_detect.sv
`timescale 1ns/1ps
module epi_line_detect #(
  parameter bit SPURIOUS_ON_SELECT = 1'b0
) (
  input wire logic clk_in,
  input wire logic rst_in,
  epi_line_if.det line
);
  import epi_pkg::*;

  logic prev_reg;
  logic [1:0] sense_reg;
  logic hit_reg;
  logic hit_next;
  logic sel_changed;

  assign sel_changed = SPURIOUS_ON_SELECT && (line.sense != sense_reg);

  always_comb begin
    unique case (line.sense)
      SENSE_LOW: hit_next = 1'b0;
      SENSE_ANY: hit_next = line.pin != prev_reg;
      // A new polarity finding the pin already at its after-edge level fires once
      SENSE_FALL: hit_next = (prev_reg && !line.pin) || (sel_changed && !line.pin);
      SENSE_RISE: hit_next = (!prev_reg && line.pin) || (sel_changed && line.pin);
    endcase
  end

  // Only sampled while the enable runs; a stopped clock sees no edges
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      prev_reg <= 1'b1;
      sense_reg <= SENSE_LOW;
      hit_reg <= 1'b0;
    end else if (line.sample_en) begin
      prev_reg <= line.pin;
      sense_reg <= line.sense;
      hit_reg <= hit_next;
    end else begin
      hit_reg <= 1'b0;
    end
  end

  assign line.edge_hit = hit_reg;

  chk_rise_edge_hit: assert property (@(posedge clk_in) disable iff (rst_in)
    (line.sample_en && line.sense == SENSE_RISE && !prev_reg && line.pin) |=> hit_reg)
    else $error("rising edge not reported");
  chk_stopped_no_hit: assert property (@(posedge clk_in) disable iff (rst_in)
    !line.sample_en |=> !hit_reg)
    else $error("edge reported while sampling stopped");
endmodule

// File: logic/epi_ext_irq.sv
`timescale 1ns/1ps
// What this block does
// - Enabled lines still raise requests while their pin is driven as an output.
// - Lines a and b take low, any change, falling or rising; line c edges only.
// - Level-triggered a or b requests as long as the pin stays low.
// - Edge detection on a and b runs only on the I/O clock enable.
// - Low level on a/b and edges on c are seen without the I/O clock.
// - I/O clock stops in every sleep mode but idle.
// - Power-down level wake samples the pin twice on watchdog ticks.
// - Watchdog tick period is nominally one microsecond.
// - Two good samples start the start-up time, then the device wakes.
// - Level gone before start-up ends: wake anyway, no level interrupt.
// - Two-bit sense: 00 low, 01 any change, 10 falling, 11 rising.
// - Line c sense bit: 0 falling, 1 rising; changing it may fire.
// - Edge flag sets on trigger, clears on ack or write-one, held clear in level.
module epi_ext_irq #(
  parameter int WDT_TICKS = epi_pkg::WDT_TICK_CYCLES
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic [epi_pkg::NUM_LINES-1:0] ext_irq_pin_in,
  output logic [epi_pkg::NUM_LINES-1:0] ext_irq_pin_out,
  output logic [epi_pkg::NUM_LINES-1:0] ext_irq_pin_oe_n_out,
  input wire logic [epi_pkg::NUM_LINES-1:0] irq_ack_in,
  input wire logic [1:0] startup_time_fuses_in,
  output logic irq_out,
  output logic io_clk_run_out,
  output logic cpu_awake_out
);
  import epi_pkg::*;

  if (WDT_TICKS < 1 || WDT_TICKS > 65535) begin : g_bad_ticks
    $error("WDT_TICKS out of range");
  end

  // Bus side
  logic wr_pend_reg;
  logic rd_pend_reg;
  logic [7:0] addr_reg;
  logic hready_reg;
  logic [31:0] hrdata_reg;
  logic accept;
  logic [31:0] rdata;

  // Software-visible state
  logic [4:0] cpu_control_reg;
  logic [2:0] ext_irq_enable_reg;
  logic global_en_reg;
  logic [2:0] ext_irq_flag_reg;
  logic [2:0] drive_reg;
  logic [2:0] dir_reg;
  logic deep_mode_reg;

  // Sleep and wake
  epi_state_t state_reg;
  epi_state_t state_next;
  logic [15:0] wdt_cnt_reg;
  logic wdt_tick_reg;
  logic [1:0] sample_cnt_reg;
  logic [15:0] start_cnt_reg;
  logic [15:0] start_target;
  logic io_run_reg;
  logic irq_reg;
  logic awake_reg;
  logic deep_now;
  logic [2:0] oe_n_reg;

  logic [2:0] level_mode;
  logic [2:0] req;
  logic [2:0] en_req;
  logic [2:0] edge_hit;
  logic [1:0] line_sense [NUM_LINES];
  logic lvl_wake;
  logic wr_flag;
  logic wr_sleep_go;

  assign accept = hsel_in && htrans_in[1] && hready_in;
  assign wr_flag = wr_pend_reg && addr_reg == OFF_FLAG;
  assign wr_sleep_go = wr_pend_reg && addr_reg == OFF_SLEEP && hwdata_in[SLEEP_GO_BIT];
  // Deep bit as it stands after this edge, so a go-with-deep write stops the I/O clock at once
  assign deep_now = (wr_pend_reg && addr_reg == OFF_SLEEP && state_reg == ST_RUN)
    ? hwdata_in[SLEEP_DEEP_BIT] : deep_mode_reg;

  assign line_sense[LINE_A] = cpu_control_reg[CTRL_A_SENSE_LSB +: 2];
  assign line_sense[LINE_B] = cpu_control_reg[CTRL_B_SENSE_LSB +: 2];
  // Line c never offers the low-level code
  assign line_sense[LINE_C] = {1'b1, cpu_control_reg[CTRL_C_SEL_BIT]};

  for (genvar g = 0; g < NUM_LINES; g++) begin : g_line
    epi_line_if lif ();
    // Detection reads the pin wire whatever the direction register says
    assign lif.pin = ext_irq_pin_in[g];
    assign lif.sense = line_sense[g];
    // Line c is watched in every state; a and b only on the I/O clock
    assign lif.sample_en = (g == LINE_C) ? 1'b1 : io_run_reg;
    assign edge_hit[g] = lif.edge_hit;
    assign level_mode[g] = (g != LINE_C) && line_sense[g] == SENSE_LOW;
    // Level request follows the pin itself, no flag involved
    assign req[g] = level_mode[g] ? !ext_irq_pin_in[g] : ext_irq_flag_reg[g];
    epi_line_detect #(
      .SPURIOUS_ON_SELECT(g == LINE_C)
    ) u_det (
      .clk_in(clock_in),
      .rst_in(rst_in),
      .line(lif.det)
    );
  end

  assign en_req = req & ext_irq_enable_reg;
  // Low level is seen combinationally, so it works with the I/O clock stopped
  assign lvl_wake = |(ext_irq_enable_reg & level_mode & ~ext_irq_pin_in);

  always_comb begin
    unique case (startup_time_fuses_in)
      2'h0: start_target = 16'(STARTUP0_CYC);
      2'h1: start_target = 16'(STARTUP1_CYC);
      2'h2: start_target = 16'(STARTUP2_CYC);
      2'h3: start_target = 16'(STARTUP3_CYC);
    endcase
  end

  always_comb begin
    rdata = 32'h0000_0000;
    unique case (addr_reg)
      OFF_CTRL: rdata[4:0] = cpu_control_reg;
      OFF_ENABLE: rdata = {24'h00_0000, global_en_reg, 4'h0, ext_irq_enable_reg};
      OFF_FLAG: rdata[2:0] = ext_irq_flag_reg;
      OFF_PIN: rdata = {21'h00_0000, dir_reg, 5'h00, drive_reg};
      OFF_SLEEP: rdata = {20'h0_0000, state_reg, 7'h00, deep_mode_reg};
      OFF_STATUS: rdata = {23'h00_0000, io_run_reg, 1'b0, en_req, 1'b0, ext_irq_pin_in};
      default: rdata = 32'h0000_0000;
    endcase
  end

  // Writes take no wait state; reads take one so read data comes from a flop
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
      hready_reg <= 1'b1;
      hrdata_reg <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= accept && hwrite_in;
      rd_pend_reg <= accept && !hwrite_in;
      if (accept) begin
        addr_reg <= {haddr_in[7:2], 2'b00};
      end
      if (accept && !hwrite_in) begin
        hready_reg <= 1'b0;
      end else if (rd_pend_reg) begin
        hready_reg <= 1'b1;
        hrdata_reg <= rdata;
      end
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      cpu_control_reg <= CTRL_RST;
      ext_irq_enable_reg <= ENABLE_RST;
      global_en_reg <= 1'b0;
      drive_reg <= DRIVE_RST;
      dir_reg <= DIR_RST;
      oe_n_reg <= ~DIR_RST;
      deep_mode_reg <= 1'b0;
    end else if (wr_pend_reg) begin
      unique case (addr_reg)
        OFF_CTRL: cpu_control_reg <= hwdata_in[4:0];
        OFF_ENABLE: begin
          ext_irq_enable_reg <= hwdata_in[2:0];
          global_en_reg <= hwdata_in[EN_GLOBAL_BIT];
        end
        OFF_PIN: begin
          drive_reg <= hwdata_in[2:0];
          dir_reg <= hwdata_in[PIN_DIR_LSB +: 3];
          oe_n_reg <= ~hwdata_in[PIN_DIR_LSB +: 3];
        end
        OFF_SLEEP: begin
          if (state_reg == ST_RUN) begin
            deep_mode_reg <= hwdata_in[SLEEP_DEEP_BIT];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Set beats clear; level mode alone holds the flag down
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ext_irq_flag_reg <= 3'h0;
    end else begin
      for (int i = 0; i < NUM_LINES; i++) begin
        if (level_mode[i]) begin
          ext_irq_flag_reg[i] <= 1'b0;
        end else if (edge_hit[i]) begin
          ext_irq_flag_reg[i] <= 1'b1;
        end else if (irq_ack_in[i] || (wr_flag && hwdata_in[i])) begin
          ext_irq_flag_reg[i] <= 1'b0;
        end
      end
    end
  end

  // Watchdog tick, one pulse per nominal microsecond
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      wdt_cnt_reg <= 16'h0000;
      wdt_tick_reg <= 1'b0;
    end else if (wdt_cnt_reg == 16'(WDT_TICKS - 1)) begin
      wdt_cnt_reg <= 16'h0000;
      wdt_tick_reg <= 1'b1;
    end else begin
      wdt_cnt_reg <= wdt_cnt_reg + 16'h0001;
      wdt_tick_reg <= 1'b0;
    end
  end

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_RUN: begin
        if (wr_sleep_go) begin
          state_next = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (!deep_mode_reg) begin
          if (|en_req) begin
            state_next = ST_RUN;
          end
        end else if (en_req[LINE_C]) begin
          state_next = ST_STARTUP;
        end else if (lvl_wake) begin
          state_next = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        if (wdt_tick_reg) begin
          if (!lvl_wake) begin
            state_next = ST_SLEEP;
          end else if (sample_cnt_reg == 2'(WAKE_SAMPLES - 1)) begin
            state_next = ST_STARTUP;
          end
        end
      end
      ST_STARTUP: begin
        // Wakes whether or not the level is still there
        if (start_cnt_reg == start_target - 16'h0001) begin
          state_next = ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= ST_RUN;
      sample_cnt_reg <= 2'h0;
      start_cnt_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      if (state_reg != ST_SAMPLE) begin
        sample_cnt_reg <= 2'h0;
      end else if (wdt_tick_reg) begin
        sample_cnt_reg <= sample_cnt_reg + 2'h1;
      end
      if (state_reg != ST_STARTUP) begin
        start_cnt_reg <= 16'h0000;
      end else begin
        start_cnt_reg <= start_cnt_reg + 16'h0001;
      end
    end
  end

  // I/O clock runs awake and in idle only
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      io_run_reg <= 1'b1;
      irq_reg <= 1'b0;
      awake_reg <= 1'b1;
    end else begin
      io_run_reg <= state_next == ST_RUN || (state_next == ST_SLEEP && !deep_now);
      awake_reg <= state_next == ST_RUN;
      // After a start-up with the level gone, req is low and nothing is raised
      irq_reg <= global_en_reg && (|en_req);
    end
  end

  assign hrdata_out = hrdata_reg;
  assign hreadyout_out = hready_reg;
  assign hresp_out = 1'b0;
  assign ext_irq_pin_out = drive_reg;
  assign ext_irq_pin_oe_n_out = oe_n_reg;
  assign irq_out = irq_reg;
  assign io_clk_run_out = io_run_reg;
  assign cpu_awake_out = awake_reg;

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);

  sequence s_sample_pass;
    state_reg == ST_SAMPLE && wdt_tick_reg && lvl_wake && sample_cnt_reg == 2'h1;
  endsequence
  sequence s_startup_end;
    state_reg == ST_STARTUP && start_cnt_reg == start_target - 16'h0001;
  endsequence

  chk_level_request: assert property (
    (global_en_reg && ext_irq_enable_reg[LINE_A] && level_mode[LINE_A]
     && !ext_irq_pin_in[LINE_A]) |=> irq_out)
    else $error("held low level did not raise irq");
  chk_level_flag_clear: assert property (level_mode[LINE_B] |=> !ext_irq_flag_reg[LINE_B])
    else $error("flag set in level mode");
  chk_flag_set_wins: assert property (
    (edge_hit[LINE_C] && wr_flag && hwdata_in[LINE_C]) |=> ext_irq_flag_reg[LINE_C])
    else $error("edge lost against clear");
  chk_global_gate: assert property (!global_en_reg |=> !irq_out)
    else $error("irq without global enable");
  chk_deep_io_stop: assert property ((state_reg == ST_SLEEP && deep_mode_reg) |-> !io_run_reg)
    else $error("io clock running in deep sleep");
  chk_two_samples: assert property (s_sample_pass |=> state_reg == ST_STARTUP)
    else $error("two good samples did not start wake");
  chk_sample_abort: assert property (
    (state_reg == ST_SAMPLE && wdt_tick_reg && !lvl_wake) |=> state_reg == ST_SLEEP)
    else $error("lost level did not return to sleep");
  chk_startup_hold: assert property ($rose(state_reg == ST_STARTUP)
    |-> (state_reg == ST_STARTUP) [*8])
    else $error("start-up cut short");
  chk_startup_wake: assert property (s_startup_end |=> cpu_awake_out)
    else $error("no wake at end of start-up");
  chk_tick_period: assert property ($rose(wdt_tick_reg) |=> !wdt_tick_reg)
    else $error("watchdog tick longer than one cycle");
  chk_line_c_edges: assert property (
    (!ext_irq_pin_in[LINE_C] && !ext_irq_flag_reg[LINE_C] && !edge_hit[LINE_C])
    |=> !req[LINE_C])
    else $error("line c requested on a low level");
endmodule

// File: verification/epi_pin_source.sv
`timescale 1ns/1ps
module epi_pin_source (
  input wire logic clock_in,
  output logic [2:0] drive_out
);
  // Idle pins sit high so a reset never sees a stray edge
  initial drive_out = 3'h7;

  task automatic set_pin(input int line, input logic val);
    @(posedge clock_in);
    drive_out[line] <= val;
  endtask

  // Low pulse lasting len clocks; len is not checked, and this bench always passes two or more
  task automatic pulse(input int line, input int len);
    set_pin(line, 1'b0);
    repeat (len) @(posedge clock_in);
    drive_out[line] <= 1'b1;
  endtask
endmodule

// File: verification/epi_ext_irq_test.sv
`timescale 1ns/1ps
module epi_ext_irq_test;
  import epi_pkg::*;
  localparam int TICKS = 4;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [2:0] ack = 3'h0;
  logic [1:0] fuses = 2'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic hready;
  logic hresp;
  logic irq;
  logic io_run;
  logic awake;
  logic [2:0] pin_out;
  logic [2:0] oe_n;
  logic [2:0] src_drv;
  logic [2:0] pin_wire;
  int n_errors = 0;
  int num_checks = 0;
  int cnt;

  always #10 clock_in = ~clock_in;

  // The device wins a pin only where its active-low enable is low
  assign pin_wire = (oe_n & src_drv) | (~oe_n & pin_out);

  epi_pin_source src (.clock_in(clock_in), .drive_out(src_drv));

  epi_ext_irq #(.WDT_TICKS(TICKS)) dut (
    .clock_in(clock_in), .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .ext_irq_pin_in(pin_wire), .ext_irq_pin_out(pin_out), .ext_irq_pin_oe_n_out(oe_n),
    .irq_ack_in(ack), .startup_time_fuses_in(fuses), .irq_out(irq),
    .io_clk_run_out(io_run), .cpu_awake_out(awake)
  );

  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t bit %b expected %b", $time, got, exp);
    end
  endtask

  task automatic wait_ready;
    @(posedge clock_in);
    while (hready !== 1'b1) @(posedge clock_in);
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_ready();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk_word(rd, exp);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
  endtask

  task automatic wait_awake(input int lim);
    cnt = 0;
    while (awake !== 1'b1 && cnt < lim) begin
      @(posedge clock_in);
      cnt++;
    end
  endtask

  // Whole run is a few thousand cycles; this bound only catches a hang
  initial begin
    #1000000;
    n_errors++;
    $display("BAD %0t watchdog expired", $time);
    test_done();
  end

  initial begin
    repeat (16) @(posedge clock_in);
    rst_in <= 1'b0;
    chk_bit(irq, 1'b0);
    chk_bit(awake, 1'b1);
    chk_word({29'h0, oe_n}, 32'h7);
    chk_word(32'(WDT_TICK_CYCLES), 32'h32);
    rdchk(OFF_CTRL, 32'h0);
    rdchk(OFF_ENABLE, 32'h0);
    rdchk(OFF_PIN, 32'h0);
    rdchk(OFF_STATUS, 32'h107);
    rdchk(8'h3C, 32'h0);
    chk_bit(hresp, 1'b0);
    for (int ln = 0; ln < 2; ln++) begin
      for (int s = 1; s < 4; s++) begin
        wr(OFF_CTRL, 32'(s) << (2 * ln));
        wr(OFF_FLAG, 32'h7);
        src.set_pin(ln, 1'b0);
        tick(3);
        rdchk(OFF_FLAG, (s != 3) ? (32'h1 << ln) : 32'h0);
        wr(OFF_FLAG, 32'h7);
        src.set_pin(ln, 1'b1);
        tick(3);
        rdchk(OFF_FLAG, (s != 2) ? (32'h1 << ln) : 32'h0);
      end
    end
    wr(OFF_CTRL, 32'h0);
    wr(OFF_FLAG, 32'h7);
    wr(OFF_ENABLE, 32'h81);
    src.set_pin(0, 1'b0);
    tick(40);
    chk_bit(irq, 1'b1);
    rdchk(OFF_FLAG, 32'h0);
    rdchk(OFF_STATUS, 32'h116);
    wr(OFF_ENABLE, 32'h1);
    tick(2);
    chk_bit(irq, 1'b0);
    wr(OFF_ENABLE, 32'h80);
    tick(2);
    chk_bit(irq, 1'b0);
    src.set_pin(0, 1'b1);
    src.pulse(2, 3);
    tick(3);
    rdchk(OFF_FLAG, 32'h4);
    chk_bit(irq, 1'b0);
    wr(OFF_ENABLE, 32'h84);
    tick(2);
    chk_bit(irq, 1'b1);
    @(posedge clock_in);
    ack <= 3'h4;
    @(posedge clock_in);
    ack <= 3'h0;
    tick(2);
    chk_bit(irq, 1'b0);
    // Pin c is high, so selecting rising edge fires at once
    wr(OFF_CTRL, 32'h10);
    tick(2);
    rdchk(OFF_FLAG, 32'h4);
    wr(OFF_FLAG, 32'h4);
    tick(2);
    chk_bit(irq, 1'b0);
    src.set_pin(2, 1'b0);
    tick(3);
    rdchk(OFF_FLAG, 32'h0);
    // Edge and write-one clear meet in one cycle; the edge must win
    fork
      src.set_pin(2, 1'b1);
      wr(OFF_FLAG, 32'h4);
    join
    tick(3);
    rdchk(OFF_FLAG, 32'h4);
    wr(OFF_CTRL, 32'h18);
    wr(OFF_PIN, 32'h202);
    tick(2);
    chk_word({29'h0, oe_n}, 32'h5);
    wr(OFF_FLAG, 32'h7);
    wr(OFF_PIN, 32'h200);
    tick(3);
    rdchk(OFF_FLAG, 32'h2);
    wr(OFF_PIN, 32'h0);
    wr(OFF_FLAG, 32'h7);
    wr(OFF_ENABLE, 32'h82);
    wr(OFF_SLEEP, 32'h10);
    tick(2);
    chk_bit(awake, 1'b0);
    chk_bit(io_run, 1'b1);
    src.pulse(1, 2);
    tick(4);
    chk_bit(awake, 1'b1);
    wr(OFF_FLAG, 32'h7);
    wr(OFF_ENABLE, 32'h84);
    wr(OFF_SLEEP, 32'h11);
    tick(2);
    chk_bit(io_run, 1'b0);
    src.pulse(1, 3);
    tick(4);
    chk_bit(awake, 1'b0);
    rdchk(OFF_FLAG, 32'h0);
    fuses <= 2'h1;
    src.set_pin(2, 1'b0);
    tick(3);
    src.set_pin(2, 1'b1);
    wait_awake(400);
    chk_bit(cnt >= STARTUP1_CYC && cnt <= STARTUP1_CYC + 8, 1'b1);
    tick(2);
    chk_bit(irq, 1'b1);
    wr(OFF_FLAG, 32'h7);
    wr(OFF_ENABLE, 32'h81);
    fuses <= 2'h3;
    wr(OFF_SLEEP, 32'h11);
    src.pulse(0, TICKS / 2);
    tick(80);
    chk_bit(awake, 1'b0);
    src.pulse(0, 3 * TICKS);
    wait_awake(3300);
    chk_bit(awake, 1'b1);
    tick(2);
    chk_bit(irq, 1'b0);
    fuses <= 2'h2;
    wr(OFF_SLEEP, 32'h11);
    src.set_pin(0, 1'b0);
    wait_awake(900);
    chk_bit(awake, 1'b1);
    chk_bit(cnt >= STARTUP2_CYC && cnt <= STARTUP2_CYC + 16, 1'b1);
    tick(2);
    chk_bit(irq, 1'b1);
    src.set_pin(0, 1'b1);
    tick(4);
    test_done();
  end
endmodule
